// ---- include/dsp_decode_defines.svh ----
// offsets, field positions, encodings, reset values and timing counts of the operand decoder
`ifndef DSP_DECODE_DEFINES_SVH
`define DSP_DECODE_DEFINES_SVH

// register byte offsets
`define OFF_INSTR 8'h00
`define OFF_CTRL 8'h04
`define OFF_FLAGS 8'h08
`define OFF_STATUS 8'h0c
`define OFF_DECODE 8'h10
`define OFF_PREFETCH 8'h14
`define OFF_LITERAL 8'h18

// reset values
`define CTRL_RST 2'h0
`define FLAGS_RST 9'h000

// instruction word fields
`define F_OPC 23:16
`define F_SIZE 15:14
`define F_SHADOW 13
`define F_ACC 15
`define F_TEN_LIT 13:4
`define F_FILE 12:0
`define F_TO_W0 13
`define F_RA 7:4
`define F_RB 3:0
`define F_DIV_IND 8
`define F_PAIR 14:12
`define F_XPF 11:8
`define F_YPF 7:4
`define F_XDST 3:2
`define F_YDST 1:0
`define F_WB_TGT 1:0
`define F_HIADDR 6:0

// ctrl and flag fields
`define CTRL_COND 0
`define CTRL_SKIP2 1
`define FLAGS_MCU 4:0
`define FLAGS_DSP 8:5

// opcodes
`define OPC_NOP 8'h00
`define OPC_ALU_REG 8'h01
`define OPC_ALU_LIT 8'h02
`define OPC_FILE 8'h03
`define OPC_BIT 8'h04
`define OPC_BRANCH_COND 8'h05
`define OPC_BRANCH 8'h06
`define OPC_IND 8'h07
`define OPC_TBL 8'h08
`define OPC_RET 8'h09
`define OPC_RETFI 8'h0a
`define OPC_SKIP 8'h0b
`define OPC_JUMP 8'h0c
`define OPC_MOVD 8'h0d
`define OPC_DIV 8'h0e
`define OPC_SQR 8'h0f
`define OPC_MAC 8'h10
`define OPC_ACCST 8'h11

// operand limits and fixed registers
`define LIT_BYTE_MAX 10'h0ff
`define PAIR_MAX 3'h5
`define WB_TGT_BAD 2'h3
`define WB_TGT_NONE 2'h0
`define REG_IMPLICIT 4'h0
`define REG_WB 4'hd
`define REG_MUL_BASE 4'h4
`define REG_X_BASE 4'h8
`define REG_Y_BASE 4'ha
`define PF_MODE_ALT 3'h7

// instruction cycle counts
`define CYC_ONE 2'h1
`define CYC_TWO 2'h2
`define CYC_THREE 2'h3
`define ICYC_CLKS 4

`endif

// ---- include/dsp_decode_pkg.sv ----
// types shared by the operand decoder and its bench
package dsp_decode_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_EXEC = 3'b010,
    ST_WORD2 = 3'b100
  } state_t;

  typedef enum logic [1:0] {
    SZ_WORD = 2'h0,
    SZ_BYTE = 2'h1,
    SZ_DWORD = 2'h2,
    SZ_BAD = 2'h3
  } size_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [3:0] regA;
    logic [3:0] regB;
    size_t size;
    logic shadow;
    logic acc;
    logic [3:0] bitPos;
    logic [1:0] cycles;
    logic [1:0] wbTgt;
    logic illegal;
    logic dword;
  } dec_t;

  typedef struct packed {
    logic [3:0] xReg;
    logic [2:0] xMode;
    logic xNone;
    logic [3:0] yReg;
    logic [2:0] yMode;
    logic yNone;
    logic [3:0] xDest;
    logic [3:0] yDest;
    logic [2:0] pair;
  } pf_t;

  typedef struct packed {
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic psel;
    logic penable;
    logic pwrite;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

endpackage

// ---- design/dsp_operand_decode.sv ----
// operand decoder and instruction cycle sequencer with an apb register port
//
// Contract
// - plain single-word instruction takes one cycle
// - true test or pc change adds nop cycle
// - branches, indirect, table, returns take two/three
// - taken skip costs two or three cycles
// - double-word instructions take exactly two cycles
// - size suffix byte/dword/word, shadow select bit
// - accumulator operand is exactly A or B
// - writeback only w13 or [w13]+=2
// - bit position field is four bits, 0..15
// - ten-bit literal max 255 in byte mode
// - program address literal lsb must be zero
// - keep carry, digit carry, negative, overflow, zero
// - keep overflow and saturate per accumulator
// - general register operands address w0..w15
// - file op to working register uses w0
// - divide uses direct register pair only
// - square pairs only w4..w7 with itself
// - multiply only six ascending w4..w7 pairs
// - x prefetch w8/w9 modes, w9+w12, none
// - y prefetch w10/w11 modes, w11+w12, none
// - prefetch destinations only w4..w7
// - 24-bit word, top eight bits opcode
// - second word top byte zero, alone nop
`timescale 1ns/1ps

`include "dsp_decode_defines.svh"

module dsp_operand_decode
  import dsp_decode_pkg::*;
#(
  parameter int ICYC_CLKS = `ICYC_CLKS
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire apb_req_t apbReq,
  output apb_rsp_t apbRsp,
  // decode results
  output dec_t decOut,
  output pf_t pfOut,
  output logic [22:0] litOut,
  output logic decValid,
  output logic illegalTrap,
  // execution timing
  output logic busy,
  output logic nopSlot,
  output logic icycTick,
  // status flags
  output logic [4:0] mcuFlags,
  output logic [3:0] dspFlags
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // declarations

  state_t state_r;
  logic [15:0] divCnt_r;
  logic [1:0] cycLeft_r;
  logic [1:0] ctrl_r;
  logic [8:0] flags_r;
  logic [23:0] instr_r;
  logic [15:0] first16_r;
  logic illegal_r;
  dec_t dec_r;
  pf_t pf_r;
  logic [22:0] lit_r;
  logic rdy_r;
  logic err_r;
  logic [31:0] rdata_r;
  logic [31:0] rdMux;
  logic [3:0] sel;
  logic access;
  logic accErr;
  logic wrFire;
  logic instrWr;
  logic [23:0] w;
  dec_t decNxt;
  pf_t pfNxt;
  logic [22:0] litNxt;
  logic [7:0] pairRegs;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // helpers

  // register select: bit 3 valid, bits 2:0 index
  function automatic logic [3:0] regSel(input logic [7:0] addr);
    logic [3:0] r;
    r = 4'h0;
    case (addr)
      `OFF_INSTR: r = 4'h8;
      `OFF_CTRL: r = 4'h9;
      `OFF_FLAGS: r = 4'ha;
      `OFF_STATUS: r = 4'hb;
      `OFF_DECODE: r = 4'hc;
      `OFF_PREFETCH: r = 4'hd;
      `OFF_LITERAL: r = 4'he;
      default: r = 4'h0;
    endcase
    return r;
  endfunction

  // ascending multiply pairs among w4..w7
  function automatic logic [7:0] mulPair(input logic [2:0] idx);
    logic [7:0] p;
    p = 8'h00;
    case (idx)
      3'h0: p = 8'h45;
      3'h1: p = 8'h46;
      3'h2: p = 8'h47;
      3'h3: p = 8'h56;
      3'h4: p = 8'h57;
      3'h5: p = 8'h67;
      default: p = 8'h00;
    endcase
    return p;
  endfunction

  function automatic logic inMulSet(input logic [3:0] r);
    return r[3:2] == 2'h1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // instruction cycle divider

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      divCnt_r <= 16'h0000;
      icycTick <= 1'b0;
    end else if (divCnt_r == 16'(ICYC_CLKS - 1)) begin
      divCnt_r <= 16'h0000;
      icycTick <= 1'b1;
    end else begin
      divCnt_r <= divCnt_r + 16'h0001;
      icycTick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer registered

  assign access = apbReq.psel && apbReq.penable;
  assign sel = regSel(apbReq.paddr);
  assign accErr = !sel[3]
    || (apbReq.pwrite && sel[2:0] >= 3'h3)
    || (apbReq.pwrite && sel == 4'h8 && state_r == ST_EXEC);
  assign wrFire = access && rdy_r && apbReq.pwrite && !err_r;
  assign instrWr = wrFire && sel == 4'h8;
  assign apbRsp = '{prdata: rdata_r, pready: rdy_r, pslverr: err_r};

  always_comb begin
    case (sel)
      4'h8: rdMux = {8'h00, instr_r};
      4'h9: rdMux = {30'h0, ctrl_r};
      4'ha: rdMux = {23'h0, flags_r};
      4'hb: rdMux = {24'h0, cycLeft_r, dec_r.cycles, illegal_r, state_r == ST_WORD2, busy,
        nopSlot};
      4'hc: rdMux = {2'h0, dec_r};
      4'hd: rdMux = {5'h0, pf_r};
      4'he: rdMux = {9'h0, lit_r};
      default: rdMux = 32'h0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdy_r <= 1'b0;
      err_r <= 1'b0;
      rdata_r <= 32'h0;
    end else if (access && !rdy_r) begin
      rdy_r <= 1'b1;
      err_r <= accErr;
      rdata_r <= apbReq.pwrite ? 32'h0 : rdMux;
    end else begin
      rdy_r <= 1'b0;
      err_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // control and status flag registers

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= `CTRL_RST;
      flags_r <= `FLAGS_RST;
    end else if (wrFire && sel == 4'h9) begin
      ctrl_r <= apbReq.pwdata[1:0];
    end else if (wrFire && sel == 4'ha) begin
      flags_r <= apbReq.pwdata[8:0];
    end
  end

  assign mcuFlags = flags_r[`FLAGS_MCU];
  assign dspFlags = flags_r[`FLAGS_DSP];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // operand decode of the written word

  assign w = apbReq.pwdata[23:0];
  assign pairRegs = mulPair(w[`F_PAIR]);

  always_comb begin
    decNxt = '0;
    pfNxt = '0;
    litNxt = 23'h0;
    decNxt.opcode = w[`F_OPC];
    decNxt.cycles = `CYC_ONE;
    case (w[`F_OPC])
      `OPC_NOP: decNxt.cycles = `CYC_ONE;
      `OPC_ALU_REG: begin
        decNxt.size = size_t'(w[`F_SIZE]);
        decNxt.shadow = w[`F_SHADOW];
        decNxt.regA = w[`F_RA];
        decNxt.regB = w[`F_RB];
        decNxt.illegal = decNxt.size == SZ_BAD;
      end
      `OPC_ALU_LIT: begin
        decNxt.size = size_t'(w[`F_SIZE]);
        decNxt.regB = w[`F_RB];
        litNxt = {13'h0, w[`F_TEN_LIT]};
        decNxt.illegal = decNxt.size == SZ_BAD
          || (decNxt.size == SZ_BYTE && w[`F_TEN_LIT] > `LIT_BYTE_MAX);
      end
      `OPC_FILE: begin
        decNxt.size = size_t'({1'b0, w[`F_SIZE] == 2'h1});
        litNxt = {10'h0, w[`F_FILE]};
        decNxt.regA = w[`F_TO_W0] ? `REG_IMPLICIT : 4'h0;
      end
      `OPC_BIT: begin
        decNxt.bitPos = w[`F_RA];
        decNxt.regB = w[`F_RB];
      end
      `OPC_BRANCH_COND: begin
        decNxt.cycles = ctrl_r[`CTRL_COND] ? `CYC_TWO : `CYC_ONE;
        litNxt = {7'h0, w[15:0]};
      end
      `OPC_BRANCH, `OPC_TBL: begin
        decNxt.cycles = `CYC_TWO;
        litNxt = {7'h0, w[15:0]};
      end
      `OPC_IND: begin
        decNxt.cycles = `CYC_TWO;
        decNxt.regA = w[`F_RB];
      end
      `OPC_RET, `OPC_RETFI: decNxt.cycles = `CYC_THREE;
      `OPC_SKIP: begin
        decNxt.bitPos = w[`F_RA];
        decNxt.regB = w[`F_RB];
        if (ctrl_r[`CTRL_COND]) begin
          decNxt.cycles = ctrl_r[`CTRL_SKIP2] ? `CYC_THREE : `CYC_TWO;
        end
      end
      `OPC_JUMP, `OPC_MOVD: begin
        decNxt.dword = 1'b1;
        decNxt.cycles = `CYC_TWO;
        litNxt = {7'h0, w[15:0]};
      end
      `OPC_DIV: begin
        decNxt.regA = w[`F_RA];
        decNxt.regB = w[`F_RB];
        decNxt.illegal = w[`F_DIV_IND];
      end
      `OPC_SQR: begin
        decNxt.acc = w[`F_ACC];
        decNxt.regA = w[`F_RA];
        decNxt.regB = w[`F_RB];
        decNxt.illegal = !(w[`F_RA] == w[`F_RB] && inMulSet(w[`F_RA]));
      end
      `OPC_MAC: begin
        decNxt.acc = w[`F_ACC];
        decNxt.regA = pairRegs[7:4];
        decNxt.regB = pairRegs[3:0];
        decNxt.illegal = w[`F_PAIR] > `PAIR_MAX;
        pfNxt.pair = w[`F_PAIR];
        pfNxt.xReg = `REG_X_BASE | {3'h0, w[11]};
        pfNxt.xMode = w[10:8];
        pfNxt.xNone = !w[11] && w[10:8] == `PF_MODE_ALT;
        pfNxt.yReg = `REG_Y_BASE | {3'h0, w[7]};
        pfNxt.yMode = w[6:4];
        pfNxt.yNone = !w[7] && w[6:4] == `PF_MODE_ALT;
        pfNxt.xDest = `REG_MUL_BASE | {2'h0, w[`F_XDST]};
        pfNxt.yDest = `REG_MUL_BASE | {2'h0, w[`F_YDST]};
      end
      `OPC_ACCST: begin
        decNxt.acc = w[`F_ACC];
        decNxt.wbTgt = w[`F_WB_TGT];
        decNxt.regB = w[`F_WB_TGT] == `WB_TGT_NONE ? 4'h0 : `REG_WB;
        decNxt.illegal = w[`F_WB_TGT] == `WB_TGT_BAD;
      end
      default: decNxt.illegal = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // sequencer: first word, second word, execution cycles

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      cycLeft_r <= 2'h0;
      dec_r <= '0;
      pf_r <= '0;
      lit_r <= 23'h0;
      instr_r <= 24'h0;
      first16_r <= 16'h0000;
      illegal_r <= 1'b0;
      decValid <= 1'b0;
      illegalTrap <= 1'b0;
    end else begin
      decValid <= 1'b0;
      illegalTrap <= 1'b0;
      if (instrWr) begin
        instr_r <= w;
      end
      case (state_r)
        ST_IDLE: begin
          if (instrWr) begin
            dec_r <= decNxt;
            pf_r <= pfNxt;
            lit_r <= litNxt;
            illegal_r <= decNxt.illegal;
            if (decNxt.illegal) begin
              illegalTrap <= 1'b1;
            end else if (decNxt.dword) begin
              first16_r <= w[15:0];
              state_r <= ST_WORD2;
            end else begin
              cycLeft_r <= decNxt.cycles;
              decValid <= 1'b1;
              state_r <= ST_EXEC;
            end
          end
        end
        ST_WORD2: begin
          if (instrWr) begin
            lit_r <= {w[`F_HIADDR], first16_r};
            if (w[`F_OPC] != `OPC_NOP
                || (dec_r.opcode == `OPC_JUMP && first16_r[0])) begin
              illegal_r <= 1'b1;
              illegalTrap <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              cycLeft_r <= dec_r.cycles;
              decValid <= 1'b1;
              state_r <= ST_EXEC;
            end
          end
        end
        ST_EXEC: begin
          if (icycTick) begin
            cycLeft_r <= cycLeft_r - 2'h1;
            if (cycLeft_r == 2'h1) begin
              state_r <= ST_IDLE;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign busy = state_r == ST_EXEC;
  assign nopSlot = busy && cycLeft_r < dec_r.cycles;
  assign decOut = dec_r;
  assign pfOut = pf_r;
  assign litOut = lit_r;

endmodule // dsp_operand_decode

// ---- sim/dsp_operand_decode_props.sv ----
// assertion checker for the operand decoder ports
`timescale 1ns/1ps
`include "dsp_decode_defines.svh"
module dsp_operand_decode_props
  import dsp_decode_pkg::*;
#(
  parameter int ICYC_CLKS = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // register bus
  input wire apb_req_t apbReq,
  input wire apb_rsp_t apbRsp,
  // decode results
  input wire dec_t decOut,
  input wire pf_t pfOut,
  input wire logic [22:0] litOut,
  input wire logic decValid,
  input wire logic illegalTrap,
  // execution timing
  input wire logic busy,
  input wire logic nopSlot
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////
  pready_pulse_a: assert property (
    apbRsp.pready |=> !apbRsp.pready) else $error("pready held");
  apb_answer_a: assert property (
    apbReq.psel && apbReq.penable && !$past(apbReq.penable) |=> apbRsp.pready)
    else $error("pready late");
  one_cycle_a: assert property (
    busy && decOut.cycles == `CYC_ONE |-> !nopSlot) else $error("nop in one cycle op");
  nop_slot_a: assert property (
    nopSlot |-> busy && decOut.cycles != `CYC_ONE) else $error("stray nop slot");
  cycle_range_a: assert property (
    decValid |-> decOut.cycles != 2'h0) else $error("zero cycles");
  dword_two_a: assert property (
    decValid && decOut.dword |-> decOut.cycles == `CYC_TWO) else $error("dword cycles");
  wb_legal_a: assert property (
    decValid |-> decOut.wbTgt != `WB_TGT_BAD) else $error("bad writeback");
  byte_lit_a: assert property (
    decValid && decOut.opcode == `OPC_ALU_LIT && decOut.size == SZ_BYTE
    |-> litOut[9:0] <= `LIT_BYTE_MAX) else $error("byte literal range");
  jump_even_a: assert property (
    decValid && decOut.opcode == `OPC_JUMP |-> !litOut[0]) else $error("odd jump");
  square_pair_a: assert property (
    decValid && decOut.opcode == `OPC_SQR
    |-> decOut.regA == decOut.regB && decOut.regA[3:2] == 2'b01) else $error("square pair");
  mac_pair_a: assert property (
    decValid && decOut.opcode == `OPC_MAC |-> pfOut.pair <= `PAIR_MAX) else $error("mac pair");
  pf_dest_a: assert property (
    decValid && decOut.opcode == `OPC_MAC
    |-> pfOut.xDest[3:2] == 2'b01 && pfOut.yDest[3:2] == 2'b01) else $error("pf dest");
  trap_idle_a: assert property (
    illegalTrap |-> !decValid && !busy) else $error("trap while running");
  cover property (decValid && decOut.cycles == `CYC_THREE);
  cover property (illegalTrap);
  cover property (decValid && decOut.dword);
  cover property (apbRsp.pready && apbRsp.pslverr);
endmodule // dsp_operand_decode_props

bind dsp_operand_decode dsp_operand_decode_props #(.ICYC_CLKS(ICYC_CLKS)) props (
  .clk(clk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp), .decOut(decOut),
  .pfOut(pfOut), .litOut(litOut), .decValid(decValid), .illegalTrap(illegalTrap),
  .busy(busy), .nopSlot(nopSlot)
);

// ---- sim/dsp_operand_decode_tb_top.sv ----
// self-checking bench for the operand decoder
`timescale 1ns/1ps
`include "dsp_decode_defines.svh"
module dsp_operand_decode_tb_top
  import dsp_decode_pkg::*;
;
  typedef struct {
    logic [23:0] w1;
    logic [23:0] w2;
    logic [1:0] ctrl;
    logic [1:0] cyc;
    logic ill;
  } row_t;
  // first word, second word, ctrl, cycles, illegal
  row_t rows [30] = '{
    '{24'h010034, 0, 0, 1, 0}, '{24'h050000, 0, 0, 1, 0}, '{24'h050000, 0, 1, 2, 0},
    '{24'h060000, 0, 0, 2, 0}, '{24'h070000, 0, 0, 2, 0}, '{24'h080000, 0, 0, 2, 0},
    '{24'h090000, 0, 0, 3, 0}, '{24'h0a0000, 0, 0, 3, 0}, '{24'h0b0000, 0, 0, 1, 0},
    '{24'h0b0000, 0, 1, 2, 0}, '{24'h0b0000, 0, 3, 3, 0},
    '{24'h0c1234, 24'h00007f, 0, 2, 0}, '{24'h0d0010, 24'h000000, 0, 2, 0},
    '{24'h0c1235, 24'h000000, 0, 0, 1}, '{24'h0d0010, 24'h010000, 0, 0, 1},
    '{24'h01c000, 0, 0, 0, 1}, '{24'h024ff0, 0, 0, 1, 0}, '{24'h025000, 0, 0, 0, 1},
    '{24'h023ff0, 0, 0, 1, 0}, '{24'h0e0100, 0, 0, 0, 1}, '{24'h0e0045, 0, 0, 1, 0},
    '{24'h0f0077, 0, 0, 1, 0}, '{24'h0f0045, 0, 0, 0, 1}, '{24'h0f0088, 0, 0, 0, 1},
    '{24'h105000, 0, 0, 1, 0}, '{24'h106000, 0, 0, 0, 1}, '{24'h110002, 0, 0, 1, 0},
    '{24'h110003, 0, 0, 0, 1}, '{24'h120000, 0, 0, 0, 1}, '{24'h000000, 0, 0, 1, 0}
  };
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  apb_req_t apbReq = '0;
  apb_rsp_t apbRsp;
  dec_t decOut;
  pf_t pfOut;
  logic [22:0] litOut;
  logic decValid;
  logic illegalTrap;
  logic busy;
  logic nopSlot;
  logic icycTick;
  logic [4:0] mcuFlags;
  logic [3:0] dspFlags;
  logic [31:0] rd;
  logic err;
  int errorCnt = 0;
  int checked = 0;
  int tickCnt = 0;
  int nopCnt = 0;
  ////////////////////////////////////////////////////////////
  always #5 clk = ~clk;
  always @(posedge clk) begin
    if (busy === 1'b1 && icycTick === 1'b1) begin
      tickCnt <= tickCnt + 1;
      nopCnt <= nopCnt + (nopSlot === 1'b1 ? 1 : 0);
    end
  end
  dsp_operand_decode #(.ICYC_CLKS(4)) DUT (
    .clk(clk), .rst_b(rst_b), .apbReq(apbReq), .apbRsp(apbRsp), .decOut(decOut),
    .pfOut(pfOut), .litOut(litOut), .decValid(decValid), .illegalTrap(illegalTrap),
    .busy(busy), .nopSlot(nopSlot), .icycTick(icycTick), .mcuFlags(mcuFlags),
    .dspFlags(dspFlags)
  );
  ////////////////////////////////////////////////////////////
  task automatic finalReport();
    $display("comparisons %0d mismatches %0d", checked, errorCnt);
    if (errorCnt == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errorCnt++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apbReq <= '{paddr: a, pwdata: d, psel: 1'b1, penable: 1'b0, pwrite: wr};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (apbRsp.pready !== 1'b1);
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask
  task automatic waitIdle();
    repeat (2) @(negedge clk);
    for (int i = 0; i < 100 && busy === 1'b1; i++) begin
      @(negedge clk);
    end
    chk("busy", 32'h0, {31'h0, busy});
  endtask
  task automatic runInstr(input row_t r);
    @(negedge clk);
    tickCnt = 0;
    nopCnt = 0;
    apb(1'b1, `OFF_CTRL, {30'h0, r.ctrl});
    apb(1'b1, `OFF_INSTR, {8'h00, r.w1});
    if (r.w1[23:16] == `OPC_JUMP || r.w1[23:16] == `OPC_MOVD) begin
      apb(1'b1, `OFF_INSTR, {8'h00, r.w2});
    end
    @(negedge clk);
    chk("valid", {31'h0, !r.ill}, {31'h0, decValid});
    chk("trap", {31'h0, r.ill}, {31'h0, illegalTrap});
    waitIdle();
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk("illegal", {31'h0, r.ill}, {31'h0, rd[3]});
    if (!r.ill) begin
      chk("cycles", {30'h0, r.cyc}, {30'h0, rd[5:4]});
      chk("ticks", {30'h0, r.cyc}, tickCnt);
      chk("nops", {30'h0, r.cyc - 2'h1}, nopCnt);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    finalReport();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("reset", 32'h0, {busy, decValid, illegalTrap, nopSlot, mcuFlags, dspFlags, apbRsp.pready});
    foreach (rows[k]) begin
      runInstr(rows[k]);
    end
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, `OFF_FLAGS, k ? 32'h05a : 32'h1a5);
      apb(1'b0, `OFF_FLAGS, 32'h0);
      chk("flags", k ? 32'h05a : 32'h1a5, {23'h0, dspFlags, mcuFlags});
      chk("flagsrd", k ? 32'h05a : 32'h1a5, rd);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, `OFF_DECODE, 32'h0);
    chk("rdonly", 32'h1, {31'h0, err});
    apb(1'b1, `OFF_CTRL, 32'h0);
    apb(1'b1, `OFF_INSTR, 32'h090000);
    apb(1'b1, `OFF_INSTR, 32'h010000);
    chk("busywr", 32'h1, {31'h0, err});
    waitIdle();
    apb(1'b1, `OFF_INSTR, 32'h0c5678);
    apb(1'b1, `OFF_INSTR, 32'h000055);
    waitIdle();
    chk("literal", 32'h555678, {9'h0, litOut});
    apb(1'b1, `OFF_INSTR, 32'h100ffb);
    waitIdle();
    chk("pf", {4'h9, 3'h7, 1'b0, 4'hb, 3'h7, 1'b0, 4'h6, 4'h7, 3'h0}, pfOut);
    apb(1'b1, `OFF_INSTR, 32'h1006e0);
    waitIdle();
    chk("pf", {4'h8, 3'h6, 1'b0, 4'hb, 3'h6, 1'b0, 4'h4, 4'h4, 3'h0}, pfOut);
    apb(1'b1, `OFF_INSTR, 32'h100770);
    waitIdle();
    chk("pfnone", 32'h3, {30'h0, pfOut.xNone, pfOut.yNone});
    apb(1'b1, `OFF_INSTR, 32'h016a5c);
    waitIdle();
    chk("alureg", {4'h5, 4'hc, 2'h1, 1'b1},
      {decOut.regA, decOut.regB, decOut.size, decOut.shadow});
    apb(1'b1, `OFF_INSTR, 32'h018000);
    waitIdle();
    chk("size", 32'h2, {30'h0, decOut.size});
    chk("opcode", 32'h1, {24'h0, decOut.opcode});
    apb(1'b1, `OFF_INSTR, 32'h0400f3);
    waitIdle();
    chk("bitpos", 32'hf3, {24'h0, decOut.bitPos, decOut.regB});
    apb(1'b1, `OFF_INSTR, 32'h032abc);
    waitIdle();
    chk("file", 32'h0abc, {9'h0, litOut});
    chk("w0", 32'h0, {28'h0, decOut.regA});
    apb(1'b1, `OFF_INSTR, 32'h10d000);
    waitIdle();
    chk("mac", 32'h167, {23'h0, decOut.acc, decOut.regA, decOut.regB});
    apb(1'b1, `OFF_INSTR, 32'h110001);
    waitIdle();
    chk("wbtgt", 32'h1d, {26'h0, decOut.wbTgt, decOut.regB});
    apb(1'b1, `OFF_INSTR, 32'h090000);
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    chk("reset2", 32'h0,
      {busy, decValid, illegalTrap, nopSlot, mcuFlags, dspFlags, apbRsp.pready});
    finalReport();
  end
endmodule // dsp_operand_decode_tb_top
